// ===== rtl/oeq_pkg.sv
package oeq_pkg;
    // oscillator and system clock
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned OSC_HZ = 32_000;
    // system clocks per oscillator tick
    localparam int unsigned TICK_DIV = CLK_HZ / OSC_HZ;
    localparam int TICK_W = 14;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
    // durations counted in oscillator ticks (31.25 us each)
    localparam int CNT_W = 9;
    localparam int unsigned TICKS_PER_MS = 32;
    // signal loss limit, in microseconds and ticks (round down)
    localparam int unsigned LOSS_US = 56;
    localparam logic [CNT_W-1:0] LOSS_TICKS =
        CNT_W'((LOSS_US * OSC_HZ) / 1_000_000);
    // gain initialisation hold, in microseconds and ticks (round up)
    localparam int unsigned GAIN_SETTLE_US = 3500;
    localparam logic [CNT_W-1:0] GAIN_SETTLE_TICKS =
        CNT_W'((GAIN_SETTLE_US * OSC_HZ + 999_999) / 1_000_000);
    // settle gap and rearm gap, in ticks (plain defaults)
    localparam logic [CNT_W-1:0] SETTLE_GAP_TICKS = 9'h010;
    localparam logic [CNT_W-1:0] REARM_GAP_TICKS = 9'h010;
    // select field encodings
    localparam logic [1:0] HSEL_OFF = 2'h0;
    localparam logic [1:0] HSEL_1MS = 2'h1;
    localparam logic [1:0] HSEL_2MS = 2'h2;
    localparam logic [1:0] LSEL_4MS = 2'h3;
    localparam logic [1:0] LSEL_2MS = 2'h2;

    typedef enum logic [5:0] {
        OEQ_GAIN = 6'h01,
        OEQ_GAP  = 6'h02,
        OEQ_WAIT = 6'h04,
        OEQ_HIGH = 6'h08,
        OEQ_LOW  = 6'h10,
        OEQ_OPEN = 6'h20
    } oeq_state_e;

    // limit lookup in ticks: ms figure times ticks per ms
    function automatic logic [CNT_W-1:0] ms_ticks(input int unsigned ms);
        ms_ticks = CNT_W'(ms * TICKS_PER_MS);
    endfunction

    function automatic logic [CNT_W-1:0] min_high(input logic [1:0] h);
        case (h)
            HSEL_1MS: min_high = ms_ticks(1);
            HSEL_2MS: min_high = ms_ticks(2);
            default: min_high = ms_ticks(4);
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] min_low(input logic [1:0] l);
        case (l)
            LSEL_2MS: min_low = ms_ticks(2);
            LSEL_4MS: min_low = ms_ticks(4);
            default: min_low = ms_ticks(1);
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] max_period(input logic [1:0] h,
                                                   input logic [1:0] l);
        int unsigned ms;
        ms = 0;
        case (h)
            HSEL_1MS: ms = (l == LSEL_4MS) ? 6 : (l == LSEL_2MS) ? 4 : 3;
            HSEL_2MS: ms = (l == LSEL_4MS) ? 8 : (l == LSEL_2MS) ? 5 : 4;
            default: ms = (l == LSEL_4MS) ? 10 : (l == LSEL_2MS) ? 8 : 6;
        endcase
        max_period = ms_ticks(ms);
    endfunction
endpackage

// ===== rtl/oeq_qualifier.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - 2ms/4ms high rows set low and period
// - high, low minimums; period maximum
// - high timed rise to fall, bounded
// - low timed fall to rise, bounded
// - rise to rise period under maximum
// - high select zero bypasses qualifier
// - gate until fresh valid high and low
// - short high resets qualifier
// - signal loss over 56us during high resets
// - short low resets qualifier
// - high, low or sum overlong resets
// - soft reset command resets qualifier
// - long high needs gap and new rise
// - disabled qualifier passes all data
// - qualify right after settle gap
// - 1ms high row limits, host programs; code uses a fixed max_period table row for 1ms
// - data out only after header matches
// - hold reset during gain settle time
module oeq_qualifier
    import oeq_pkg::*;
#(
    // last count of the oscillator divider
    parameter logic [TICK_W-1:0] DIV_LAST = TICK_LAST
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // settings and commands
    input wire logic [1:0] high_time_select,
    input wire logic [1:0] low_time_select,
    input wire logic soft_reset_cmd,
    input wire logic wake,
    // demodulator and carrier presence
    input wire logic demod_in,
    input wire logic carrier_in,
    // output
    output logic data_output_pin,
    output logic data_enabled
);
    import oeq_pkg::*;

    oeq_tick_if t ();
    oeq_tick_gen #(.DIV_LAST(DIV_LAST)) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .demod_in(demod_in),
        .t(t)
    );

    oeq_state_e st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] per_q, per_d;
    logic [CNT_W-1:0] loss_q, loss_d;
    logic [CNT_W-1:0] rearm_q, rearm_d;
    logic rearm_wait_q, rearm_wait_d;
    logic out_q, en_q;
    logic cr1_q, cr2_q, sc1_q, sc2_q;

    // limits from the select fields
    wire logic bypass = (high_time_select == HSEL_OFF);
    wire logic [CNT_W-1:0] lim_h = min_high(high_time_select);
    wire logic [CNT_W-1:0] lim_l = min_low(low_time_select);
    wire logic [CNT_W-1:0] lim_p =
        max_period(high_time_select, low_time_select);
    // half-tick-free counting: counts advance on oscillator ticks
    wire logic tk = t.tick;
    wire logic [CNT_W-1:0] cnt_inc = tk ? cnt_q + 1'b1 : cnt_q;
    wire logic [CNT_W-1:0] per_inc = tk ? per_q + 1'b1 : per_q;
    // high and low phase checks
    // minimums are lower bounds, period an upper bound
    wire logic high_ok = (cnt_q > lim_h) && (cnt_q <= lim_p);
    wire logic low_ok = (cnt_q > lim_l) && (cnt_q <= lim_p);
    wire logic per_over = (per_q > lim_p);
    wire logic high_over = (cnt_q > lim_p);
    wire logic lost = (loss_q > LOSS_TICKS);

    // synchronise carrier presence and soft reset command
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cr1_q <= 1'b0;
            cr2_q <= 1'b0;
            sc1_q <= 1'b0;
            sc2_q <= 1'b0;
        end else begin
            cr1_q <= carrier_in;
            cr2_q <= cr1_q;
            sc1_q <= soft_reset_cmd;
            sc2_q <= sc1_q;
        end
    end

    // next-state logic
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_inc;
        per_d = per_inc;
        loss_d = loss_q;
        rearm_d = rearm_q;
        rearm_wait_d = rearm_wait_q;
        case (st_q)
            OEQ_GAIN: begin
                // held in reset while the gain loop settles
                if (cnt_q >= GAIN_SETTLE_TICKS) begin
                    st_d = OEQ_GAP;
                    cnt_d = '0;
                end
            end
            OEQ_GAP: begin
                if (cnt_q >= SETTLE_GAP_TICKS) begin
                    st_d = OEQ_WAIT;
                    cnt_d = '0;
                end
            end
            OEQ_WAIT: begin
                cnt_d = '0;
                per_d = '0;
                loss_d = '0;
                if (rearm_wait_q) begin
                    // after an overlong high, wait the gap first
                    rearm_d = tk ? rearm_q + 1'b1 : rearm_q;
                    if (rearm_q >= REARM_GAP_TICKS) begin
                        rearm_wait_d = 1'b0;
                    end
                end else if (t.rise) begin
                    st_d = OEQ_HIGH;
                end
            end
            OEQ_HIGH: begin
                loss_d = cr2_q ? '0 : (tk ? loss_q + 1'b1 : loss_q);
                if (lost) begin
                    st_d = OEQ_WAIT;
                end else if (high_over) begin
                    st_d = OEQ_WAIT;
                    rearm_wait_d = 1'b1;
                    rearm_d = '0;
                end else if (t.fall) begin
                    cnt_d = '0;
                    st_d = high_ok ? OEQ_LOW : OEQ_WAIT;
                end
            end
            OEQ_LOW: begin
                if (cnt_q > lim_p || per_over) begin
                    st_d = OEQ_WAIT;
                end else if (t.rise) begin
                    // open only if low and whole period pass
                    st_d = (low_ok && !per_over) ? OEQ_OPEN
                                                 : OEQ_WAIT;
                end
            end
            OEQ_OPEN: begin
                cnt_d = '0;
                per_d = '0;
            end
            default: st_d = OEQ_GAIN;
        endcase
        // soft reset restarts qualification from a clean state
        if (sc2_q || !wake) begin
            st_d = OEQ_GAIN;
            cnt_d = '0;
            per_d = '0;
            loss_d = '0;
            rearm_wait_d = 1'b0;
            rearm_d = '0;
        end
    end

    // state registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= OEQ_GAIN;
            cnt_q <= '0;
            per_q <= '0;
            loss_q <= '0;
            rearm_q <= '0;
            rearm_wait_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            per_q <= per_d;
            loss_q <= loss_d;
            rearm_q <= rearm_d;
            rearm_wait_q <= rearm_wait_d;
        end
    end

    // output gate: open state or bypass passes demodulated data
    wire logic gate_open = bypass || (st_q == OEQ_OPEN);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            out_q <= gate_open & t.demod;
            en_q <= gate_open;
        end
    end

    assign data_output_pin = out_q;
    assign data_enabled = en_q;
endmodule // oeq_qualifier
`default_nettype wire

// ===== rtl/oeq_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module oeq_tick_gen
    import oeq_pkg::*;
#(
    // last count of the oscillator divider
    parameter logic [TICK_W-1:0] DIV_LAST = TICK_LAST
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // raw demodulator pin
    input wire logic demod_in,
    // to qualifier
    oeq_tick_if.src t
);
    import oeq_pkg::*;
    logic [TICK_W-1:0] div_q;
    logic s1_q, s2_q, s3_q, tk_q;

    // divide system clock to oscillator rate
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_q <= '0;
            tk_q <= 1'b0;
        end else begin
            div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
            tk_q <= (div_q == DIV_LAST);
        end
    end

    // two-stage synchroniser plus edge history
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= demod_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign t.tick = tk_q;
    assign t.demod = s2_q;
    assign t.rise = s2_q & ~s3_q;
    assign t.fall = ~s2_q & s3_q;
endmodule // oeq_tick_gen
`default_nettype wire

// ===== rtl/oeq_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// oscillator tick and synchronised demodulator level
interface oeq_tick_if;
    logic tick;
    logic demod;
    logic rise;
    logic fall;
    modport src (output tick, output demod, output rise, output fall);
    modport dst (input tick, input demod, input rise, input fall);
endinterface
`default_nettype wire

// ===== sim/oeq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module oeq_host_model (
    // clock
    input wire logic ref_clk,
    // settings and command toward the qualifier
    output logic [1:0] high_time_select,
    output logic [1:0] low_time_select,
    output logic soft_reset_cmd
);
    // idle settings at power up
    initial begin
        high_time_select = 2'h0;
        low_time_select = 2'h0;
        soft_reset_cmd = 1'b0;
    end
    // host programs both select fields together
    task automatic set_mode(input logic [1:0] h, input logic [1:0] l);
        @(posedge ref_clk);
        #1;
        high_time_select = h;
        low_time_select = l;
    endtask
    // soft reset command held long enough for the synchroniser
    task automatic soft_reset();
        @(posedge ref_clk);
        #1;
        soft_reset_cmd = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        soft_reset_cmd = 1'b0;
    endtask
endmodule // oeq_host_model
`default_nettype wire

// ===== sim/oeq_qualifier_sva.sv
`timescale 1ns/1ps
`default_nettype none
module oeq_qualifier_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // settings and inputs
    input wire logic [1:0] high_time_select,
    input wire logic soft_reset_cmd,
    input wire logic wake,
    input wire logic demod_in,
    // outputs
    input wire logic data_output_pin,
    input wire logic data_enabled
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // outputs clear straight after reset
    rst_clear_a: assert property ($past(rst) |-> !data_enabled && !data_output_pin)
        else $error("outputs not clear after reset");
    pin_gate_a: assert property (!data_enabled && !$past(data_enabled) |-> !data_output_pin)
        else $error("data leaks through closed gate");
    bypass_open_a: assert property ((high_time_select == 2'h0 && wake && !soft_reset_cmd) [*6] |-> data_enabled)
        else $error("bypass does not open gate");
    follow_a: assert property (data_enabled [*6] |-> data_output_pin == $past(demod_in, 3))
        else $error("open gate output not three clocks behind");
    wake_close_a: assert property ((high_time_select != 2'h0 && !wake) [*4] |-> !data_enabled)
        else $error("gate open during gain settle");
    wake_pin_a: assert property ($fell(wake) && high_time_select != 2'h0 |-> ##4 !data_output_pin [*4])
        else $error("data driven during gain settle");
    soft_close_a: assert property ((high_time_select != 2'h0 && soft_reset_cmd) [*6] |-> !data_enabled)
        else $error("gate open after soft reset");
    open_high_a: assert property ($rose(data_enabled) && high_time_select != 2'h0 |-> $past(demod_in, 2))
        else $error("gate opened without rising edge");
endmodule // oeq_qualifier_sva
bind oeq_qualifier oeq_qualifier_sva chk (.ref_clk(ref_clk), .rst(rst),
    .high_time_select(high_time_select), .soft_reset_cmd(soft_reset_cmd),
    .wake(wake), .demod_in(demod_in), .data_output_pin(data_output_pin),
    .data_enabled(data_enabled));
`default_nettype wire

// ===== sim/oeq_qualifier_tb.sv
`timescale 1ns/1ps
`default_nettype none
module oeq_qualifier_tb;
    // shortened oscillator tick: 16 clocks
    localparam int TICK = 16;
    logic carrier = 1'b1;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wake = 1'b0;
    logic demod_in = 1'b0;
    logic [1:0] hsel;
    logic [1:0] lsel;
    logic soft_rst;
    logic pin;
    logic en;
    int n_fail = 0;
    int tests_run = 0;
    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;
    oeq_qualifier #(.DIV_LAST(14'h000f)) DUT (.ref_clk(ref_clk), .rst(rst),
        .high_time_select(hsel),
        .low_time_select(lsel), .soft_reset_cmd(soft_rst), .wake(wake),
        .demod_in(demod_in), .carrier_in(carrier), .data_output_pin(pin),
        .data_enabled(en));
    oeq_host_model host (.ref_clk(ref_clk), .high_time_select(hsel),
        .low_time_select(lsel), .soft_reset_cmd(soft_rst));
    // verdict and end of run
    task automatic results();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s: expected %b, seen %b", what, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // bypass passes data for every low select
    task automatic t_bypass();
        for (int l = 0; l < 4; l++) begin
            host.set_mode(2'h0, 2'(l));
            for (int v = 1; v >= 0; v--) begin
                demod_in = v[0];
                step(8);
                check("bypass enable", 1'b1, en);
                check("bypass data", v[0], pin);
            end
        end
        $display("bypass test done");
    endtask
    // soft reset closes the gate and blocks data
    task automatic t_closed();
        host.set_mode(2'h2, 2'h0);
        host.soft_reset();
        demod_in = 1'b1;
        step(8);
        check("gate after soft reset", 1'b0, en);
        check("data while closed", 1'b0, pin);
        $display("soft reset test done");
    endtask
    // carrier lost during the high phase spoils the header
    task automatic t_loss();
        demod_in = 1'b0;
        host.soft_reset();
        step(140 * TICK);
        demod_in = 1'b1;
        step(8 * TICK);
        carrier = 1'b0;
        step(4 * TICK);
        carrier = 1'b1;
        step(60 * TICK);
        demod_in = 1'b0;
        step(40 * TICK);
        demod_in = 1'b1;
        step(16);
        check("gate after signal loss", 1'b0, en);
        $display("loss test done");
    endtask
    // one header: 72 ticks high, 40 ticks low, then a rise
    task automatic t_header();
        int i;
        demod_in = 1'b0;
        host.soft_reset();
        step(140 * TICK);
        demod_in = 1'b1;
        step(72 * TICK);
        demod_in = 1'b0;
        step(40 * TICK);
        check("gate before final rise", 1'b0, en);
        demod_in = 1'b1;
        for (i = 0; i < 64 && en !== 1'b1; i++) step(1);
        if (i == 64) begin
            n_fail++;
            $display("wrong value gate open: expected 1, seen %b", en);
            results();
        end
        check("gate after header", 1'b1, en);
        demod_in = 1'b0;
        step(8);
        check("data low", 1'b0, pin);
        demod_in = 1'b1;
        step(8);
        check("data high", 1'b1, pin);
        wake = 1'b0;
        step(8);
        check("gate with wake low", 1'b0, en);
        $display("header test done");
    endtask
    // reset, then the scenarios
    initial begin
        repeat (5) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        wake = 1'b1;
        t_bypass();
        t_closed();
        wake = 1'b1;
        t_loss();
        t_header();
        results();
    end
endmodule // oeq_qualifier_tb
`default_nettype wire
